// ==== design/fwrp_pkg.sv ====
// shared constants of the four-wire register port
package fwrp_pkg;
	localparam int BYTE_W = 8; // every link unit is one byte
	localparam int IDX_W = 13; // flat register index width
	localparam int REG_BYTES = 4352; // 17 pages of 256 bytes
	localparam logic [IDX_W-1:0] LAST_IDX = 13'h10FF; // highest flat index
	localparam logic [7:0] ID_FIRST = 8'h02; // lowest page identifier
	localparam logic [7:0] ID_LAST = 8'h12; // highest page identifier
	localparam int ID_READ_BIT = 7; // set in the identifier for a read
	localparam logic [7:0] REG_RESET = 8'h00; // register contents after reset
	localparam logic [7:0] IMM_PAGE = 8'h02; // page that holds immediate registers
	localparam logic [7:0] IMM_ADDR_LAST = 8'h0F; // immediate class ends here
	localparam int SYS_CLK_NS = 25; // sys_clk period
	localparam int SCK_HALF_NS = 400; // half period of the serial clock made by the host
	localparam int SCK_HALF_CYC = SCK_HALF_NS / SYS_CLK_NS; // sys_clk cycles per half period
endpackage

// ==== design/fwrp_link_if.sv ====
// the four serial wires between host and device
interface fwrp_link_if;
	logic sel_n; // serial_select_n, low while a transfer runs
	logic sck; // serial clock made by the host
	logic sdi; // host to device data
	logic sdo; // device to host data
	modport dev (input sel_n, input sck, input sdi, output sdo);
	modport host (output sel_n, output sck, output sdi, input sdo);
endinterface

// ==== design/fwrp_device.sv ====
// device end: serial framing, register pages and frame reflection
// Operation
// RULE1 - bytes travel least significant bit first
// RULE2 - host lowers select before any transfer
// RULE3 - data changes on fall, sampled on rise; the host takes each returned sdo bit on the fall
// RULE4 - identifier, start address, then data bytes
// RULE5 - 02h-12h write, 82h-92h read
// RULE6 - bad identifier: ignore rest of transfer
// RULE7 - write stores bytes at incrementing address
// RULE8 - only complete bytes alter registers
// RULE9 - write returns old contents on output
// RULE10 - read dummy bytes are never stored
// RULE11 - read returns contents from start address
// RULE12 - host ends transfer by raising select
// RULE13 - host talks only in standby or window
// RULE14 - frame-class writes apply at reflection point
// RULE15 - immediate-class writes apply at once
// RULE16 - host splits non-contiguous updates into transfers
// RULE17 - seventeen pages of 256 byte addresses
// RULE18 - raised select drops partial byte, resets framing
// RULE19 - output byte aligned with input byte position
module fwrp_device
	import fwrp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	fwrp_link_if.dev link,
	input wire logic standby,
	input wire logic frame_reflect,
	input wire logic [IDX_W-1:0] cfg_idx,
	output logic [7:0] cfg_data,
	output logic reflect_busy
);

	typedef enum logic [1:0] {ST_ID, ST_ADDR, ST_DATA, ST_SKIP} fwrp_dev_state_e;

	// identifier check shared by framing
	function automatic logic id_ok(input logic [7:0] id);
		logic [7:0] page;
		page = {1'b0, id[6:0]};
		id_ok = (page >= ID_FIRST) && (page <= ID_LAST); // RULE5
	endfunction

	// flat index of an address inside the page named by an identifier
	function automatic logic [IDX_W-1:0] page_idx(input logic [7:0] id, input logic [7:0] addr);
		logic [4:0] page;
		page = id[4:0] - ID_FIRST[4:0];
		page_idx = {page, addr}; // RULE17
	endfunction

	// register class: a small block at the start of the first page applies at once
	function automatic logic is_immediate(input logic [IDX_W-1:0] idx);
		is_immediate = (idx[IDX_W-1:8] == 5'h00) && (idx[7:0] <= IMM_ADDR_LAST) && (IMM_PAGE == ID_FIRST);
	endfunction

	// pins come from the host's domain: three flops, accepted when stages two and three agree
	logic [2:0] pin_in; // {sel_n, sck, sdi}
	logic [2:0] s1_q, s2_q, s3_q, flt_q, flt_d;
	logic sck_prev_q; // filtered sck a cycle late, for edge finding
	assign pin_in = {link.sel_n, link.sck, link.sdi};

	generate
		for (genvar g = 0; g < 3; g++) begin : g_sync
			always_comb begin
				flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
			end
		end
	endgenerate

	// synchroniser and filter registers; select idles high so no transfer is seen at reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 3'h4;
			s2_q <= 3'h4;
			s3_q <= 3'h4;
			flt_q <= 3'h4;
			sck_prev_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
			sck_prev_q <= flt_q[1];
		end
	end

	logic sel_n_f, sdi_f, rise, fall;
	assign sel_n_f = flt_q[2];
	assign sdi_f = flt_q[0];
	assign rise = flt_q[1] & ~sck_prev_q; // RULE3
	assign fall = ~flt_q[1] & sck_prev_q;

	// register storage: link image, active image seen by the sensor, pending marks
	logic [7:0] mem_q [REG_BYTES];
	logic [7:0] act_q [REG_BYTES];
	logic dirty_q [REG_BYTES];

	// framing state
	fwrp_dev_state_e st_q, st_d;
	logic [2:0] cnt_q, cnt_d; // bit position within the byte
	logic [7:0] sin_q, sin_d; // input shifter
	logic [7:0] id_q, id_d; // accepted identifier
	logic [7:0] addr_q, addr_d; // current register address
	logic [7:0] out_q, out_d; // output shifter
	logic sdo_q, sdo_d;
	logic [7:0] rx_byte; // byte formed by the current rising edge
	logic wr_en; // one byte to store this cycle
	logic [IDX_W-1:0] wr_idx;

	// next framing values
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sin_d = sin_q;
		id_d = id_q;
		addr_d = addr_q;
		out_d = out_q;
		sdo_d = sdo_q;
		wr_en = 1'b0;
		wr_idx = page_idx(id_q, addr_q);
		rx_byte = {sdi_f, sin_q[7:1]}; // RULE1
		if (sel_n_f) begin
			// deselected: any half byte is dropped and the next byte is an identifier
			st_d = ST_ID; // RULE18 RULE12 RULE2
			cnt_d = 3'h0;
			sdo_d = 1'b0;
		end else if (rise) begin
			sin_d = rx_byte;
			cnt_d = cnt_q + 3'h1;
			if (cnt_q == 3'h7) begin // RULE8 RULE4
				case (st_q)
					ST_ID: begin
						if (id_ok(rx_byte)) begin
							id_d = rx_byte;
							st_d = ST_ADDR;
						end else begin
							st_d = ST_SKIP; // RULE6
						end
					end
					ST_ADDR: begin
						// fetch before any store so a write shows the old value
						addr_d = rx_byte;
						out_d = mem_q[page_idx(id_q, rx_byte)]; // RULE11 RULE9
						st_d = ST_DATA;
					end
					ST_DATA: begin
						wr_en = ~id_q[ID_READ_BIT]; // RULE7 RULE10
						addr_d = addr_q + 8'h01;
						out_d = mem_q[page_idx(id_q, addr_q + 8'h01)]; // RULE9 RULE11
					end
					default: begin
						st_d = ST_SKIP;
					end
				endcase
			end
		end else if (fall && st_q == ST_DATA) begin
			// each output bit leaves on the fall ahead of the matching input bit
			sdo_d = out_q[0]; // RULE19 RULE1
			out_d = {1'b0, out_q[7:1]};
		end
	end

	// framing registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_ID;
			cnt_q <= 3'h0;
			sin_q <= 8'h00;
			id_q <= ID_FIRST;
			addr_q <= 8'h00;
			out_q <= 8'h00;
			sdo_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sin_q <= sin_d;
			id_q <= id_d;
			addr_q <= addr_d;
			out_q <= out_d;
			sdo_q <= sdo_d;
		end
	end

	assign link.sdo = sdo_q;

	// reflection sweep: walks every index once per reflection point, copying pending bytes
	logic sw_act_q, sw_act_d;
	logic [IDX_W-1:0] sw_idx_q, sw_idx_d;
	logic copy_en;
	logic [7:0] cfg_data_q, cfg_data_d;

	always_comb begin
		sw_act_d = sw_act_q;
		sw_idx_d = sw_idx_q;
		copy_en = 1'b0;
		cfg_data_d = (cfg_idx <= LAST_IDX) ? act_q[cfg_idx] : 8'h00;
		if (!sw_act_q) begin
			if (frame_reflect) begin // RULE14
				sw_act_d = 1'b1;
				sw_idx_d = '0;
			end
		end else if (!wr_en) begin
			// a link store takes the array this cycle, so the sweep waits
			copy_en = dirty_q[sw_idx_q];
			sw_idx_d = sw_idx_q + 13'h0001;
			if (sw_idx_q == LAST_IDX) begin
				sw_act_d = 1'b0;
			end
		end
	end

	// sweep and read-back registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sw_act_q <= 1'b0;
			sw_idx_q <= '0;
			cfg_data_q <= 8'h00;
		end else begin
			sw_act_q <= sw_act_d;
			sw_idx_q <= sw_idx_d;
			cfg_data_q <= cfg_data_d;
		end
	end

	// register arrays; copy and store never share a cycle, and a new store marks again
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < REG_BYTES; i++) begin
				mem_q[i] <= REG_RESET;
				act_q[i] <= REG_RESET;
				dirty_q[i] <= 1'b0;
			end
		end else begin
			if (copy_en) begin
				act_q[sw_idx_q] <= mem_q[sw_idx_q]; // RULE14
				dirty_q[sw_idx_q] <= 1'b0;
			end
			if (wr_en) begin
				mem_q[wr_idx] <= rx_byte; // RULE7
				if (standby || is_immediate(wr_idx)) begin
					act_q[wr_idx] <= rx_byte; // RULE15
				end else begin
					dirty_q[wr_idx] <= 1'b1; // RULE14
				end
			end
		end
	end

	assign cfg_data = cfg_data_q;
	assign reflect_busy = sw_act_q;

endmodule

// ==== design/fwrp_host.sv ====
// host end: makes the serial clock and runs one framed transfer per request
module fwrp_host
	import fwrp_pkg::*;
#(
	parameter int HALF_CYC = SCK_HALF_CYC
)(
	input wire logic sys_clk,
	input wire logic rstn,
	fwrp_link_if.host link,
	input wire logic start,
	input wire logic [7:0] tx_id,
	input wire logic [7:0] tx_addr,
	input wire logic [7:0] tx_count,
	input wire logic [7:0] wdata,
	output logic wdata_take,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic busy,
	output logic done
);

	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_SHIFT, H_END, H_GAP} fwrp_host_state_e;

	// returned data arrives from the device's domain: three flops and agreement filter
	logic s1_q, s2_q, s3_q, sdo_f_q, sdo_f_d;
	always_comb begin
		sdo_f_d = (s2_q == s3_q) ? s3_q : sdo_f_q;
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			sdo_f_q <= 1'b0;
		end else begin
			s1_q <= link.sdo;
			s2_q <= s1_q;
			s3_q <= s2_q;
			sdo_f_q <= sdo_f_d;
		end
	end

	fwrp_host_state_e st_q, st_d;
	logic [15:0] cnt_q, cnt_d; // half period divider
	logic sck_q, sck_d, sel_n_q, sel_n_d, sdi_q, sdi_d;
	logic [2:0] bit_q, bit_d;
	logic [8:0] byte_q, byte_d, total_q, total_d; // byte index and bytes in this transfer
	logic [7:0] tx_q, tx_d, rx_q, rx_d, addr_q, addr_d;
	logic take_q, take_d, rdv_q, rdv_d, done_q, done_d;
	logic busy_q, busy_d; // registered so the user sees a clean level
	logic [7:0] rx_byte, next_tx;
	logic half_end;

	assign half_end = (cnt_q == 16'(HALF_CYC - 1));

	// next transfer values
	always_comb begin
		st_d = st_q;
		cnt_d = half_end ? 16'h0000 : cnt_q + 16'h0001;
		sck_d = sck_q;
		sel_n_d = sel_n_q;
		sdi_d = sdi_q;
		bit_d = bit_q;
		byte_d = byte_q;
		total_d = total_q;
		tx_d = tx_q;
		rx_d = rx_q;
		addr_d = addr_q;
		take_d = 1'b0;
		rdv_d = 1'b0;
		done_d = 1'b0;
		rx_byte = {sdo_f_q, rx_q[7:1]};
		next_tx = (byte_q == 9'h000) ? addr_q : wdata;
		case (st_q)
			H_IDLE: begin
				cnt_d = 16'h0000;
				if (start) begin
					// select drops and the first bit is set up before the first rise
					st_d = H_SETUP;
					sel_n_d = 1'b0; // RULE2
					tx_d = tx_id;
					sdi_d = tx_id[0];
					addr_d = tx_addr;
					total_d = {1'b0, tx_count} + 9'h002; // RULE4
					bit_d = 3'h0;
					byte_d = 9'h000;
				end
			end
			H_SETUP: begin
				if (half_end) begin
					st_d = H_SHIFT;
					sck_d = 1'b1;
				end
			end
			H_SHIFT: begin
				if (half_end) begin
					if (!sck_q) begin
						sck_d = 1'b1;
					end else begin
						// fall: take the returned bit, then change the outgoing bit
						sck_d = 1'b0;
						rx_d = rx_byte;
						if (bit_q == 3'h7) begin
							if (byte_q >= 9'h002) begin
								rdv_d = 1'b1;
							end
							if (byte_q + 9'h001 == total_q) begin
								st_d = H_END;
							end else begin
								byte_d = byte_q + 9'h001;
								bit_d = 3'h0;
								tx_d = next_tx;
								sdi_d = next_tx[0];
								take_d = (byte_q != 9'h000);
							end
						end else begin
							bit_d = bit_q + 3'h1;
							tx_d = {1'b0, tx_q[7:1]};
							sdi_d = tx_q[1]; // RULE3 RULE1
						end
					end
				end
			end
			H_END: begin
				if (half_end) begin
					st_d = H_GAP;
					sel_n_d = 1'b1; // RULE12
				end
			end
			H_GAP: begin
				// select stays high long enough for the device filter to see it
				if (half_end) begin
					st_d = H_IDLE;
					done_d = 1'b1;
				end
			end
			default: begin
				st_d = H_IDLE;
				sel_n_d = 1'b1;
				sck_d = 1'b0;
			end
		endcase
		// busy follows the state that is about to be entered
		busy_d = (st_d != H_IDLE);
	end

	// transfer registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= H_IDLE;
			cnt_q <= 16'h0000;
			sck_q <= 1'b0;
			sel_n_q <= 1'b1;
			sdi_q <= 1'b0;
			bit_q <= 3'h0;
			byte_q <= 9'h000;
			total_q <= 9'h000;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			addr_q <= 8'h00;
			take_q <= 1'b0;
			rdv_q <= 1'b0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sck_q <= sck_d;
			sel_n_q <= sel_n_d;
			sdi_q <= sdi_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			total_q <= total_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			addr_q <= addr_d;
			take_q <= take_d;
			rdv_q <= rdv_d;
			done_q <= done_d;
			busy_q <= busy_d;
		end
	end

	assign link.sck = sck_q;
	assign link.sel_n = sel_n_q;
	assign link.sdi = sdi_q;
	assign wdata_take = take_q;
	assign rdata = rx_q;
	assign rdata_valid = rdv_q;
	assign busy = busy_q;
	assign done = done_q;

endmodule

// ==== testbench/fwrp_asserts.sv ====
// wire-level checks on the link between host and device
module fwrp_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sel_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sck_q; // sck a cycle late, for edge finding
	logic [11:0] rise_q; // sck rises in this transfer
	logic [11:0] rise_d;
	// count rises while selected; idle clears so each transfer starts at zero
	always_comb begin
		rise_d = (sck && !sck_q) ? rise_q + 12'h001 : rise_q;
		if (sel_n) begin
			rise_d = 12'h000;
		end
	end
	// register helper state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sck_q <= 1'b0;
			rise_q <= 12'h000;
		end else begin
			sck_q <= sck;
			rise_q <= rise_d;
		end
	end
	// half periods of 8 cycles: the bench runs the host with its shortest safe divider
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_sdi_fall; !sel_n && !$past(sel_n) && $changed(sdi) |-> $fell(sck); endproperty
	a_sdi_fall: assert property (p_sdi_fall) else $error("sdi moved off a falling sck");
	property p_sck_idle; sel_n |-> !sck; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck high while deselected");
	property p_sck_lead; $fell(sel_n) |-> !sck [*8]; endproperty
	a_sck_lead: assert property (p_sck_lead) else $error("sck rose too soon after select");
	property p_sck_low; $fell(sck) |-> !sck [*8]; endproperty
	a_sck_low: assert property (p_sck_low) else $error("sck low phase short");
	property p_sck_high; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
	a_sck_high: assert property (p_sck_high) else $error("sck high phase wrong");
	property p_sdo_hold; sck && $past(sck) |-> $stable(sdo); endproperty
	a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved while sck high");
	property p_sdo_hdr; !sel_n && rise_q < 12'h010 |-> !sdo; endproperty
	a_sdo_hdr: assert property (p_sdo_hdr) else $error("sdo busy in header bytes");
	property p_sel_gap; $rose(sel_n) |-> sel_n [*3]; endproperty
	a_sel_gap: assert property (p_sel_gap) else $error("select high too short");
	property p_bytes; $rose(sel_n) |-> rise_q[2:0] == 3'h0 && rise_q >= 12'h010; endproperty
	a_bytes: assert property (p_bytes) else $error("transfer not whole bytes");
	c_one: cover property ($rose(sel_n) && rise_q == 12'h018);
	c_three: cover property ($rose(sel_n) && rise_q == 12'h028);
	c_sdo: cover property ($rose(sdo));
endmodule

// ==== testbench/four_wire_register_port_tb.sv ====
// bench: host and device joined, plus a hand-driven second link
module four_wire_register_port_tb import fwrp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0; // 40 MHz
	logic rstn = 1'b0;
	logic start, standby, frame_reflect, reflect_busy, wdata_take, rdata_valid, done, sck_d, busy;
	logic [7:0] tx_id, tx_addr, tx_count, wdata, rdata, cfg_data, cfg_data2, sh;
	logic [IDX_W-1:0] cfg_idx; // shared by both devices
	logic [7:0] mem [REG_BYTES]; // expected active image
	logic [7:0] bad [4] = '{8'h01, 8'h13, 8'h81, 8'h93}; // refused identifiers
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int nb_cap = 0; // bits caught of the first byte
	fwrp_link_if link ();
	fwrp_link_if link2 (); // hand-driven, to cut a byte short
	always #12.5 sys_clk = ~sys_clk;
	fwrp_host #(.HALF_CYC(8)) fwrp_host_i (.sys_clk(sys_clk), .rstn(rstn), .link(link.host), .start(start),
		.tx_id(tx_id), .tx_addr(tx_addr), .tx_count(tx_count), .wdata(wdata), .wdata_take(wdata_take),
		.rdata(rdata), .rdata_valid(rdata_valid), .busy(busy), .done(done));
	fwrp_device fwrp_device_i (.sys_clk(sys_clk), .rstn(rstn), .link(link.dev), .standby(standby),
		.frame_reflect(frame_reflect), .cfg_idx(cfg_idx), .cfg_data(cfg_data), .reflect_busy(reflect_busy));
	fwrp_device fwrp_device_i2 (.sys_clk(sys_clk), .rstn(rstn), .link(link2.dev), .standby(1'b1),
		.frame_reflect(1'b0), .cfg_idx(cfg_idx), .cfg_data(cfg_data2), .reflect_busy());
	fwrp_asserts fwrp_asserts_i (.sys_clk(sys_clk), .rstn(rstn), .sel_n(link.sel_n), .sck(link.sck),
		.sdi(link.sdi), .sdo(link.sdo));
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// cfg_data follows the index one cycle later
	task automatic img(input logic [IDX_W-1:0] idx);
		cfg_idx <= idx;
		repeat (2) @(posedge sys_clk);
		chk(cfg_data, mem[idx]);
	endtask
	// one host transfer, data bytes d, d+1, ...; every returned byte checked
	task automatic xfer(input logic [7:0] id, input logic [7:0] a, input int n, input logic [7:0] d,
		input logic upd);
		logic ok;
		logic [IDX_W-1:0] idx;
		int k;
		int t;
		ok = {1'b0, id[6:0]} >= ID_FIRST && {1'b0, id[6:0]} <= ID_LAST;
		k = 0;
		t = 0;
		tx_id <= id;
		tx_addr <= a;
		tx_count <= 8'(n);
		wdata <= d;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(posedge sys_clk);
		chk({7'h00, busy}, 8'h01);
		for (int i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge sys_clk);
			if (wdata_take === 1'b1) begin
				t++;
				wdata <= d + 8'(t);
			end
			if (rdata_valid === 1'b1) begin
				idx = {id[4:0] - 5'h02, a + 8'(k)};
				chk(rdata, ok ? mem[idx] : 8'h00);
				if (ok && !id[7] && upd) begin
					mem[idx] = d + 8'(k);
				end
				k++;
			end
		end
		chk({7'h00, busy}, 8'h00);
		chk(8'(k), 8'(n));
		chk(sh, id);
	endtask
	// nb bits on the second link, least significant first, data moved on falls
	task automatic bang(input logic [7:0] b, input int nb);
		for (int i = 0; i < nb; i++) begin
			link2.sdi <= b[i];
			repeat (8) @(posedge sys_clk);
			link2.sck <= 1'b1;
			repeat (8) @(posedge sys_clk);
			link2.sck <= 1'b0;
		end
	endtask
	// write one byte at page 02h, possibly cut short
	task automatic frame2(input logic [7:0] a, input logic [7:0] d, input int nb);
		link2.sel_n <= 1'b0;
		bang(8'h02, 8);
		bang(a, 8);
		bang(d, nb);
		repeat (8) @(posedge sys_clk);
		link2.sel_n <= 1'b1;
		link2.sdi <= ~link2.sdi; // released line shows no stale level
		repeat (8) @(posedge sys_clk);
	endtask
	// catch the first byte off the wire; cut a hung run short
	always @(posedge sys_clk) begin
		sck_d <= link.sck;
		cyc <= cyc + 1;
		if (link.sel_n) begin
			nb_cap <= 0;
		end else if (link.sck && !sck_d && nb_cap < 8) begin
			sh <= {link.sdi, sh[7:1]};
			nb_cap <= nb_cap + 1;
		end
		if (cyc == 40000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		start = 1'b0;
		standby = 1'b1;
		frame_reflect = 1'b0;
		tx_id = 8'h00;
		tx_addr = 8'h00;
		tx_count = 8'h00;
		wdata = 8'h00;
		cfg_idx = 13'h0000;
		link2.sel_n = 1'b1;
		link2.sck = 1'b0;
		link2.sdi = 1'b0;
		foreach (mem[i]) begin
			mem[i] = REG_RESET;
		end
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		xfer(8'h02, 8'hFE, 3, 8'h11, 1'b1);
		img(13'h00FE);
		img(13'h0000);
		$display("test wrap done");
		xfer(8'h82, 8'hFE, 3, 8'hE7, 1'b0);
		img(13'h00FF);
		$display("test read done");
		for (int p = 2; p <= 18; p++) begin
			xfer(8'(p), 8'(p), 1, 8'(p + 64), 1'b1);
			xfer(8'(p + 128), 8'(p), 1, 8'h00, 1'b0);
		end
		$display("test pages done");
		for (int i = 0; i < 4; i++) begin
			xfer(bad[i], 8'h30, 2, 8'hC3, 1'b1);
		end
		img(13'h0030);
		img(13'h1030);
		$display("test refuse done");
		standby <= 1'b0;
		xfer(8'h03, 8'h20, 2, 8'h5A, 1'b0);
		img(13'h0120);
		mem[13'h0120] = 8'h5A;
		mem[13'h0121] = 8'h5B;
		frame_reflect <= 1'b1;
		@(posedge sys_clk);
		frame_reflect <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({7'h00, reflect_busy}, 8'h01);
		for (int i = 0; i < 6000 && reflect_busy !== 1'b0; i++) begin
			@(posedge sys_clk);
		end
		img(13'h0120);
		img(13'h0121);
		standby <= 1'b1;
		$display("test reflect done");
		frame2(8'h20, 8'hC3, 4);
		frame2(8'h21, 8'h3C, 8);
		img(13'h0020);
		chk(cfg_data2, 8'h00);
		img(13'h0021);
		chk(cfg_data2, 8'h3C);
		$display("test abort done");
		end_of_test;
	end
endmodule
